//--- core/cbf_pkg.sv
package cbf_pkg;

  // data and register widths
  localparam int CBF_DW = 16;
  localparam int CBF_FLAGS_W = 11;
  localparam int CBF_BANK_BIT = 4;
  localparam int CBF_REG_AW = 4;
  localparam int CBF_GPR_AW = 3;
  localparam int CBF_NUM_GPR = 6;
  localparam int CBF_BYTE_MSB = 7;

  // register port offsets
  localparam logic [CBF_REG_AW-1:0] CBF_OFS_BASE = 4'h0;
  localparam logic [CBF_REG_AW-1:0] CBF_OFS_FLAGS = 4'h1;

  // values after reset
  localparam logic [CBF_DW-1:0] CBF_BASE_RST = 16'h0000;
  localparam logic [CBF_FLAGS_W-1:0] CBF_FLAGS_RST = 11'h000;
  localparam logic [CBF_DW-1:0] CBF_RDATA_RST = 16'h0000;

  // flag register layout, lsb is carry
  typedef struct packed {
    logic [4:0] spare;
    logic ovf;
    logic bank;
    logic sign;
    logic zero;
    logic debug;
    logic carry;
  } cbf_flags_t;

  // one alu result with the flags that the instruction defines
  typedef struct packed {
    logic valid;
    logic word;
    logic [CBF_DW-1:0] result;
    logic carry;
    logic ovf;
    logic def_c;
    logic def_z;
    logic def_s;
    logic def_o;
  } cbf_alu_upd_t;

endpackage

//--- core/cbf_bank_mem.sv
`timescale 1ns/10ps
module cbf_bank_mem #(
  parameter int DW = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read side
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rdata_ff;

  // storage, no reset on the array
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // registered read, zero when idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (re) begin
      rdata_ff <= mem_q[raddr];
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata = rdata_ff;

endmodule

//--- core/cbf_flag_calc.sv
`timescale 1ns/10ps
module cbf_flag_calc (
  // flags before the result
  input cbf_pkg::cbf_flags_t base,
  // alu result
  input cbf_pkg::cbf_alu_upd_t upd,
  // flags after the result
  output cbf_pkg::cbf_flags_t nxt
);
  import cbf_pkg::*;

  logic res_zero;
  logic res_neg;

  // zero and sign follow the operand size
  always_comb begin
    if (upd.word) begin
      res_zero = (upd.result == 16'h0000); // RL5
      res_neg = upd.result[CBF_DW-1]; // RL6
    end else begin
      res_zero = (upd.result[CBF_BYTE_MSB:0] == 8'h00); // RL5
      res_neg = upd.result[CBF_BYTE_MSB]; // RL6
    end
  end

  // undefined flags keep their value
  always_comb begin
    nxt = base; // RL10
    if (upd.valid) begin
      if (upd.def_c) begin
        nxt.carry = upd.carry; // RL3
      end
      if (upd.def_z) begin
        nxt.zero = res_zero; // RL5
      end
      if (upd.def_s) begin
        nxt.sign = res_neg; // RL6
      end
      if (upd.def_o) begin
        nxt.ovf = upd.ovf; // RL8
      end
    end
  end

endmodule

//--- core/cbf_core.sv
`timescale 1ns/10ps
// How it works
// RL1 - a 16-bit static base register supplies the base-relative addressing base
// RL2 - an 11-bit flag register holds the processor state
// RL3 - carry flag takes carry, borrow or shifted-out bit from the alu
// RL4 - software keeps the debug flag at zero; it is only for debugging
// RL5 - zero flag is 1 for a zero arithmetic result, else 0
// RL6 - sign flag is 1 for a negative arithmetic result, else 0
// RL7 - bank flag 0 selects register bank 0, 1 selects bank 1
// RL8 - overflow flag is 1 when an operation overflows, else 0
// RL9 - bank switch redirects register accesses, contents of both banks stay intact
// RL10 - flags an instruction does not define keep their previous value
module cbf_core #(
  parameter int GPR_NUM = cbf_pkg::CBF_NUM_GPR
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // register port
  input wire logic [cbf_pkg::CBF_REG_AW-1:0] REG_ADDR,
  input wire logic [cbf_pkg::CBF_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [cbf_pkg::CBF_DW-1:0] REG_RDATA,
  // alu result
  input cbf_pkg::cbf_alu_upd_t ALU_UPD,
  // general register access
  input wire logic GPR_WR,
  input wire logic [cbf_pkg::CBF_GPR_AW-1:0] GPR_WADDR,
  input wire logic [cbf_pkg::CBF_DW-1:0] GPR_WDATA,
  input wire logic GPR_RD,
  input wire logic [cbf_pkg::CBF_GPR_AW-1:0] GPR_RADDR,
  output logic [cbf_pkg::CBF_DW-1:0] GPR_RDATA,
  // core state
  output logic [cbf_pkg::CBF_DW-1:0] STATIC_BASE,
  output cbf_pkg::cbf_flags_t CPU_FLAGS,
  output logic BANK_SEL
);
  import cbf_pkg::*;

  localparam int MEM_AW = CBF_GPR_AW + 1;
  localparam logic [CBF_GPR_AW:0] GPR_LIM = (CBF_GPR_AW + 1)'(GPR_NUM);

  logic [CBF_DW-1:0] base_ff;
  logic [CBF_DW-1:0] nxt_base;
  cbf_flags_t flags_ff;
  cbf_flags_t nxt_flags;
  cbf_flags_t flags_base;
  logic [CBF_DW-1:0] rdata_ff;
  logic [CBF_DW-1:0] nxt_rdata;
  logic base_wr;
  logic flags_wr;
  logic gpr_we;
  logic gpr_re;
  logic [MEM_AW-1:0] gpr_waddr;
  logic [MEM_AW-1:0] gpr_raddr;

  // register offset decode
  function automatic logic reg_hit(input logic [CBF_REG_AW-1:0] addr,
                                   input logic [CBF_REG_AW-1:0] ofs);
    return addr == ofs;
  endfunction

  // general register index check
  function automatic logic gpr_ok(input logic [CBF_GPR_AW-1:0] idx);
    return {1'b0, idx} < GPR_LIM;
  endfunction

  assign base_wr = REG_WR && reg_hit(REG_ADDR, CBF_OFS_BASE);
  assign flags_wr = REG_WR && reg_hit(REG_ADDR, CBF_OFS_FLAGS);

  // static base register
  always_comb begin
    nxt_base = base_ff;
    if (base_wr) begin
      nxt_base = REG_WDATA; // RL1
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      base_ff <= CBF_BASE_RST;
    end else begin
      base_ff <= nxt_base; // RL1
    end
  end

  // flag register, the alu wins over a software write on defined flags
  always_comb begin
    flags_base = flags_ff;
    if (flags_wr) begin
      flags_base = cbf_flags_t'(REG_WDATA[CBF_FLAGS_W-1:0]); // RL2
    end
  end

  cbf_flag_calc u_calc (
    .base(flags_base),
    .upd(ALU_UPD),
    .nxt(nxt_flags)
  );

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      flags_ff <= cbf_flags_t'(CBF_FLAGS_RST);
    end else begin
      flags_ff <= nxt_flags; // RL2
    end
  end

  // read data stand in the cycle after the strobe only
  always_comb begin
    nxt_rdata = CBF_RDATA_RST;
    if (REG_RD) begin
      if (reg_hit(REG_ADDR, CBF_OFS_BASE)) begin
        nxt_rdata = base_ff; // RL1
      end else if (reg_hit(REG_ADDR, CBF_OFS_FLAGS)) begin
        nxt_rdata = {{(CBF_DW - CBF_FLAGS_W){1'b0}}, flags_ff}; // RL2
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff <= CBF_RDATA_RST;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // banked general registers, the bank flag picks the copy
  assign gpr_we = GPR_WR && gpr_ok(GPR_WADDR);
  assign gpr_re = GPR_RD && gpr_ok(GPR_RADDR);
  assign gpr_waddr = {flags_ff.bank, GPR_WADDR}; // RL7
  assign gpr_raddr = {flags_ff.bank, GPR_RADDR}; // RL9

  cbf_bank_mem #(
    .DW(CBF_DW),
    .AW(MEM_AW)
  ) u_mem (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .we(gpr_we),
    .waddr(gpr_waddr),
    .wdata(GPR_WDATA),
    .re(gpr_re),
    .raddr(gpr_raddr),
    .rdata(GPR_RDATA)
  );

  assign REG_RDATA = rdata_ff;
  assign STATIC_BASE = base_ff;
  assign CPU_FLAGS = flags_ff;
  assign BANK_SEL = flags_ff.bank; // RL7

  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  // last value written to each banked slot, seen by the checks only
  logic [CBF_DW-1:0] shadow_q [2**MEM_AW];
  logic [2**MEM_AW-1:0] shadow_vld_ff;

  always_ff @(posedge CLK_SYS) begin
    if (gpr_we) begin
      shadow_q[gpr_waddr] <= GPR_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      shadow_vld_ff <= '0;
    end else if (gpr_we) begin
      shadow_vld_ff[gpr_waddr] <= 1'b1;
    end
  end

  sequence base_write_s;
    REG_WR && reg_hit(REG_ADDR, CBF_OFS_BASE);
  endsequence

  sequence base_read_s;
    REG_RD && reg_hit(REG_ADDR, CBF_OFS_BASE);
  endsequence

  sequence flags_write_s;
    REG_WR && reg_hit(REG_ADDR, CBF_OFS_FLAGS);
  endsequence

  sequence flags_read_s;
    REG_RD && reg_hit(REG_ADDR, CBF_OFS_FLAGS);
  endsequence

  sequence reg_miss_s;
    REG_RD && !reg_hit(REG_ADDR, CBF_OFS_BASE) && !reg_hit(REG_ADDR, CBF_OFS_FLAGS);
  endsequence

  sequence alu_zero_s;
    ALU_UPD.valid && ALU_UPD.def_z;
  endsequence

  sequence alu_sign_s;
    ALU_UPD.valid && ALU_UPD.def_s;
  endsequence

  sequence quiet_s;
    !ALU_UPD.valid && !flags_wr;
  endsequence

  sequence co_undef_s;
    ALU_UPD.valid && !ALU_UPD.def_c && !ALU_UPD.def_o && !flags_wr;
  endsequence

  sequence zs_undef_s;
    ALU_UPD.valid && !ALU_UPD.def_z && !ALU_UPD.def_s && !flags_wr;
  endsequence

  sequence gpr_read_s;
    GPR_RD && gpr_ok(GPR_RADDR) && shadow_vld_ff[{BANK_SEL, GPR_RADDR}] && !gpr_we;
  endsequence

  sequence gpr_miss_s;
    GPR_RD && !gpr_ok(GPR_RADDR);
  endsequence

  base_load_a: assert property (base_write_s |=> STATIC_BASE == $past(REG_WDATA)) // RL1
    else $error("static base did not take the written value");

  base_hold_a: assert property (!base_wr [*2] |-> $stable(STATIC_BASE)) // RL1
    else $error("static base changed without a write");

  base_read_a: assert property (base_read_s |=> REG_RDATA == $past(STATIC_BASE)) // RL1
    else $error("static base read returned wrong value");

  flags_load_a: assert property (flags_write_s ##0 !ALU_UPD.valid // RL2
      |=> CPU_FLAGS == $past(REG_WDATA[CBF_FLAGS_W-1:0]))
    else $error("flag register did not take the written value");

  flags_read_a: assert property (flags_read_s // RL2
      |=> REG_RDATA == {{(CBF_DW - CBF_FLAGS_W){1'b0}}, $past(CPU_FLAGS)})
    else $error("flag read returned wrong value");

  rd_idle_a: assert property (!REG_RD |=> REG_RDATA == CBF_RDATA_RST) // RL2
    else $error("read data present without a read strobe");

  rd_miss_a: assert property (reg_miss_s |=> REG_RDATA == CBF_RDATA_RST) // RL2
    else $error("read of an unused offset returned data");

  debug_keep_a: assert property (!flags_wr |=> $stable(CPU_FLAGS.debug)) // RL2
    else $error("debug flag changed without a software write");

  carry_take_a: assert property (ALU_UPD.valid && ALU_UPD.def_c // RL3
      |=> CPU_FLAGS.carry == $past(ALU_UPD.carry))
    else $error("carry flag does not follow the alu");

  zero_flag_a: assert property (alu_zero_s // RL5
      |=> CPU_FLAGS.zero == ($past(ALU_UPD.word)
      ? ($past(ALU_UPD.result) == 16'h0000)
      : ($past(ALU_UPD.result[CBF_BYTE_MSB:0]) == 8'h00)))
    else $error("zero flag wrong after alu result");

  sign_flag_a: assert property (alu_sign_s // RL6
      |=> CPU_FLAGS.sign == ($past(ALU_UPD.word)
      ? $past(ALU_UPD.result[CBF_DW-1])
      : $past(ALU_UPD.result[CBF_BYTE_MSB])))
    else $error("sign flag wrong after alu result");

  ovf_flag_a: assert property (ALU_UPD.valid && ALU_UPD.def_o // RL8
      |=> CPU_FLAGS.ovf == $past(ALU_UPD.ovf))
    else $error("overflow flag does not follow the alu");

  flag_keep_a: assert property (quiet_s |=> $stable(CPU_FLAGS)) // RL10
    else $error("flags changed with no update");

  undef_keep_a: assert property (co_undef_s // RL10
      |=> $stable(CPU_FLAGS.carry) && $stable(CPU_FLAGS.ovf))
    else $error("undefined flag changed");

  zs_keep_a: assert property (zs_undef_s // RL10
      |=> $stable(CPU_FLAGS.zero) && $stable(CPU_FLAGS.sign))
    else $error("undefined zero or sign flag changed");

  spare_keep_a: assert property (!flags_wr |=> $stable(CPU_FLAGS.spare)) // RL10
    else $error("spare flag bits changed without a software write");

  bank_sel_a: assert property (flags_write_s ##1 !flags_wr // RL7
      |-> BANK_SEL == $past(REG_WDATA[CBF_BANK_BIT]))
    else $error("bank select does not follow the flag write");

  bank_keep_a: assert property (!flags_wr |=> $stable(BANK_SEL)) // RL7
    else $error("bank select changed without a flag write");

  bank_read_a: assert property (gpr_read_s // RL9
      |=> GPR_RDATA == shadow_q[$past({BANK_SEL, GPR_RADDR})])
    else $error("banked register read returned wrong copy");

  gpr_idle_a: assert property (!GPR_RD |=> GPR_RDATA == 16'h0000) // RL9
    else $error("register data present without a read strobe");

  gpr_miss_a: assert property (gpr_miss_s |=> GPR_RDATA == 16'h0000) // RL9
    else $error("read of an unused register returned data");

endmodule

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import cbf_pkg::*;
  localparam logic [3:0] OFS_BASE = 4'h0;
  localparam logic [3:0] OFS_FLAGS = 4'h1;
  localparam logic [3:0] OFS_NONE = 4'h5;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  cbf_alu_upd_t alu_upd = '0;
  logic gpr_wr = 1'b0;
  logic [2:0] gpr_waddr = 3'h0;
  logic [15:0] gpr_wdata = 16'h0000;
  logic gpr_rd = 1'b0;
  logic [2:0] gpr_raddr = 3'h0;
  logic [15:0] reg_rdata;
  logic [15:0] gpr_rdata;
  logic [15:0] static_base;
  cbf_flags_t cpu_flags;
  logic bank_sel;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] rng = 32'h796a;
  logic [15:0] m_base;
  logic [10:0] m_flags;
  int m_gpr[2][8];

  always #2.5 clk_sys = ~clk_sys;

  cbf_core #(.GPR_NUM(6)) uut (
    .CLK_SYS(clk_sys), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ALU_UPD(alu_upd),
    .GPR_WR(gpr_wr), .GPR_WADDR(gpr_waddr), .GPR_WDATA(gpr_wdata), .GPR_RD(gpr_rd),
    .GPR_RADDR(gpr_raddr), .GPR_RDATA(gpr_rdata), .STATIC_BASE(static_base),
    .CPU_FLAGS(cpu_flags), .BANK_SEL(bank_sel)
  );

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic idle_edge;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    gpr_wr <= 1'b0;
    gpr_rd <= 1'b0;
    alu_upd <= '0;
    #1;
  endtask

  task automatic check_state;
    check("static_base", static_base, m_base);
    check("cpu_flags", {5'h00, cpu_flags}, {5'h00, m_flags});
    check("bank_sel", {15'h0000, bank_sel}, {15'h0000, m_flags[4]});
  endtask

  task automatic do_reset;
    resetn <= 1'b0;
    @(posedge clk_sys);
    #1;
    m_base = 16'h0000;
    m_flags = 11'h000;
    check_state();
    check("reg_rdata_rst", reg_rdata, 16'h0000);
    @(posedge clk_sys);
    resetn <= 1'b1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    idle_edge();
    if (a == OFS_BASE) m_base = d;
    else if (a == OFS_FLAGS) m_flags = d[10:0];
    check_state();
  endtask

  task automatic reg_read(input logic [3:0] a);
    logic [15:0] exp;
    exp = (a == OFS_BASE) ? m_base : (a == OFS_FLAGS) ? {5'h00, m_flags} : 16'h0000;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    idle_edge();
    check("reg_rdata", reg_rdata, exp);
    @(posedge clk_sys);
    #1;
    check("reg_rdata_idle", reg_rdata, 16'h0000);
  endtask

  task automatic alu_op(input logic w, input logic [15:0] r, input logic c, input logic o,
                        input logic [3:0] defs);
    @(posedge clk_sys);
    alu_upd <= '{valid: 1'b1, word: w, result: r, carry: c, ovf: o,
                 def_c: defs[3], def_z: defs[2], def_s: defs[1], def_o: defs[0]};
    idle_edge();
    if (defs[3]) m_flags[0] = c;
    if (defs[2]) m_flags[2] = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
    if (defs[1]) m_flags[3] = w ? r[15] : r[7];
    if (defs[0]) m_flags[5] = o;
    check_state();
  endtask

  task automatic gpr_write(input logic [2:0] i, input logic [15:0] d);
    @(posedge clk_sys);
    gpr_wr <= 1'b1;
    gpr_waddr <= i;
    gpr_wdata <= d;
    idle_edge();
    if (i < 6) m_gpr[m_flags[4]][i] = d;
  endtask

  task automatic gpr_read(input logic [2:0] i);
    @(posedge clk_sys);
    gpr_rd <= 1'b1;
    gpr_raddr <= i;
    idle_edge();
    check("gpr_rdata", gpr_rdata, (i < 6) ? 16'(m_gpr[m_flags[4]][i]) : 16'h0000);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    final_report();
  end

  initial begin
    logic [31:0] r;
    do_reset();
    reg_write(OFS_BASE, 16'ha5c3);
    reg_read(OFS_BASE);
    reg_write(OFS_FLAGS, 16'hfffd);
    reg_read(OFS_FLAGS);
    reg_write(OFS_NONE, 16'h1234);
    reg_read(OFS_NONE);
    alu_op(1'b1, 16'h0000, 1'b0, 1'b0, 4'h4);
    alu_op(1'b0, 16'h0100, 1'b1, 1'b0, 4'h6);
    alu_op(1'b0, 16'h0080, 1'b0, 1'b1, 4'hf);
    alu_op(1'b1, 16'h8000, 1'b1, 1'b1, 4'hf);
    alu_op(1'b1, 16'h0001, 1'b0, 1'b0, 4'h0);
    for (int k = 0; k < 60; k++) begin
      r = rnd();
      alu_op(r[16], r[15:0], r[17], r[18], r[22:19]);
      if (k % 8 == 7) begin
        reg_write(OFS_FLAGS, r[31:16] & 16'hfffd);
        reg_write(OFS_BASE, r[15:0]);
        reg_read(OFS_FLAGS);
      end
    end
    for (int b = 0; b < 2; b++) begin
      reg_write(OFS_FLAGS, 16'(b << 4));
      for (int i = 0; i < 8; i++) begin
        r = rnd();
        gpr_write(3'(i), r[15:0]);
      end
    end
    for (int b = 1; b >= 0; b--) begin
      reg_write(OFS_FLAGS, 16'(b << 4));
      for (int i = 0; i < 8; i++) gpr_read(3'(i));
    end
    do_reset();
    reg_read(OFS_FLAGS);
    final_report();
  end
endmodule
